// File: hdl/rqh_device.sv
// Receive queue device end: frame store, head registers, DMA data
// window and receive thresholds. Frames arrive on a plain write port.
// Assumes one clock, host strobes synchronous and one cycle long.
`default_nettype none

// Function
// RULE_01 - Control one: flow control, receive enable
// RULE_02 - Control two: checksum and filter settings
// RULE_03 - Head status register shows head frame
// RULE_04 - Head byte count low 12 bits
// RULE_05 - Bit 3 starts DMA data window
// RULE_06 - Bit 4 dequeues frames as read
// RULE_07 - Bit 9 inserts two-byte offset
// RULE_08 - Pointer bit 14 auto-increments address
// RULE_09 - Duration threshold sets bits 13, 12
// RULE_10 - Byte threshold sets bits 13, 11
// RULE_11 - Frame threshold sets bits 13, 10
// RULE_12 - Enable bit 13 gates interrupt
// RULE_13 - Write ones clears status bits
// RULE_14 - Frame count high byte at interrupt
// RULE_15 - First DMA read is dummy
// RULE_16 - Host reads to double-word boundary
// RULE_17 - Clearing interrupt updates frame count
// RULE_18 - Frame count read loads head registers
// RULE_19 - Both head reads load next frame
// RULE_20 - Frame: status, count, data up to 2000
// RULE_21 - Threshold status sticky, interrupt is OR
module rqh_device
  import rqh_pkg::*;
#(
  parameter int MEM_WORDS   = 2048, // Queue storage in 16-bit words
  parameter int MAX_FRAMES  = 16    // Frames the queue can hold
)(
  input  wire logic  clock,         // System clock
  input  wire logic  reset_n,       // Asynchronous reset, active low
  rqh_if.device      bus,           // Host register port
  input  wire logic  in_valid,      // Incoming word strobe
  input  wire logic [15:0] in_word, // Incoming word: status, count, data
  input  wire logic  in_last,       // Marks last word of a frame
  output logic       in_ready,      // Device can take a word
  output logic       rx_enable,     // Receive block enabled
  output logic       rx_flow_ctrl,  // Receive flow control enabled
  output logic [15:0] rx_ctrl_two   // Checksum and filter settings
);

  localparam int AW = $clog2(MEM_WORDS);
  localparam int FW = $clog2(MAX_FRAMES + 1);

  // Frame store, written by the receive side only
  logic [15:0] mem [MEM_WORDS];

  typedef struct packed {
    logic [15:0] ctrl1, ctrl2, qctrl, dptr, dthr, bthr, interrupt_enable, interrupt_status, fthr;
    logic [15:0] head_st, head_bc, rdata;
    logic [7:0]  fc_snap;
    logic        rd_st, rd_bc, dummy, irq;
    logic [AW-1:0] wptr, fstart, rbase;
    logic [FW-1:0] frames;
    logic [15:0] bytes;
    logic [15:0] age_us;
    logic [3:0]  tick;
    logic [10:0] pos;
  } rqh_dev_t;

  rqh_dev_t s_q, s_d;

  // Words spanned by a frame of a given byte count, rounded to dwords
  function automatic logic [AW-1:0] frame_words(input logic [15:0] bc);
    logic [15:0] w;
    w = ((bc + 16'h0003) >> 2) << 1;
    return AW'(w + 16'h0002);
  endfunction

  // ******************************************************************
  // Frame store write from the receive side
  // ******************************************************************
  always_ff @(posedge clock)
  begin
    if (in_valid && in_ready)
      mem[s_q.wptr] <= in_word;                              // RULE_20
  end

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb
  begin
    logic [15:0] data_w;
    logic        ev_f, ev_b, ev_d, thr, deq;
    logic [AW-1:0] cur_bc;
    deq = 1'b0;
    cur_bc = AW'(1);
    s_d = s_q;
    data_w = RESET_ZERO;
    s_d.rdata = RESET_ZERO;
    s_d.irq = 1'b0;

    // Incoming frames; refused while the store or frame slots are full
    if (in_valid && in_ready)
    begin
      s_d.wptr = s_q.wptr + AW'(1);
      if (in_last)
      begin
        s_d.frames = s_q.frames + FW'(1);
        s_d.bytes = s_q.bytes + 16'(mem[s_q.fstart + AW'(1)]);
        s_d.fstart = s_q.wptr + AW'(1);
      end
    end

    // Duration timer counts 1 us ticks while frames wait
    if (s_q.frames == '0)
    begin
      s_d.age_us = '0;
      s_d.tick = '0;
    end
    else if (s_q.tick == 4'(TICK_CYCLES - 1))
    begin
      s_d.tick = '0;
      if (s_q.age_us != ALL_ONES)
        s_d.age_us = s_q.age_us + 16'h0001;
    end
    else
      s_d.tick = s_q.tick + 4'h1;

    // Host writes
    if (bus.wr)
    begin
      if (bus.addr == OFS_RX_CTRL_ONE)
        s_d.ctrl1 = bus.wdata;                               // RULE_01
      else if (bus.addr == OFS_RX_CTRL_TWO)
        s_d.ctrl2 = bus.wdata;                               // RULE_02
      else if (bus.addr == OFS_QUEUE_CTRL)
      begin
        s_d.qctrl = (s_q.qctrl & ~QCTRL_WR_MASK)
                  | (bus.wdata & QCTRL_WR_MASK);
        // Closing the DMA pass with auto-dequeue set releases the frame just read
        deq = s_q.qctrl[BIT_DMA_START] && !bus.wdata[BIT_DMA_START] &&
              s_q.qctrl[BIT_AUTO_DEQ] && s_q.frames != '0;
        if (bus.wdata[BIT_DMA_START] && !s_q.qctrl[BIT_DMA_START])
        begin
          s_d.dummy = 1'b1;                                  // RULE_15
          s_d.pos = bus.wdata[BIT_IP_OFFSET] ? 11'd2 : 11'd0; // RULE_07
        end
      end
      else if (bus.addr == OFS_DATA_POINTER)
      begin
        s_d.dptr = bus.wdata;
        s_d.pos = bus.wdata[10:0];
      end
      else if (bus.addr == OFS_DUR_THRESH)
        s_d.dthr = bus.wdata;
      else if (bus.addr == OFS_BYTE_THRESH)
        s_d.bthr = bus.wdata;
      else if (bus.addr == OFS_INT_ENABLE)
        s_d.interrupt_enable = bus.wdata;
      else if (bus.addr == OFS_INT_STATUS)
      begin
        s_d.interrupt_status = s_q.interrupt_status & ~bus.wdata;                      // RULE_13
        if (bus.wdata[BIT_RX_INT] && s_q.interrupt_status[BIT_RX_INT])
        begin
          s_d.fc_snap = 8'(s_q.frames);                      // RULE_17
          s_d.qctrl[BIT_DUR_STAT:BIT_FCNT_STAT] = 3'b000;    // RULE_21
        end
      end
      else if (bus.addr == OFS_FRAME_THRESH)
        s_d.fthr = {8'h00, bus.wdata[7:0]};
    end

    // Threshold events, sticky until cleared; set wins over clear
    ev_f = s_q.qctrl[BIT_FCNT_EN] && 8'(s_q.frames) > s_q.fthr[7:0]; // RULE_11
    ev_b = s_q.qctrl[BIT_BCNT_EN] && s_q.bytes > s_q.bthr;  // RULE_10
    ev_d = s_q.qctrl[BIT_DUR_EN] && s_q.age_us > s_q.dthr;  // RULE_09
    thr = ev_f | ev_b | ev_d;                                // RULE_21
    if (ev_f) s_d.qctrl[BIT_FCNT_STAT] = 1'b1;
    if (ev_b) s_d.qctrl[BIT_BCNT_STAT] = 1'b1;
    if (ev_d) s_d.qctrl[BIT_DUR_STAT] = 1'b1;
    if (thr)
    begin
      s_d.interrupt_status[BIT_RX_INT] = 1'b1;
      if (!s_q.interrupt_status[BIT_RX_INT])
        s_d.fc_snap = 8'(s_q.frames);                        // RULE_14
    end

    // Host reads
    if (bus.rd)
    begin
      if (bus.addr == OFS_RX_CTRL_ONE)       s_d.rdata = s_q.ctrl1;
      else if (bus.addr == OFS_RX_CTRL_TWO)  s_d.rdata = s_q.ctrl2;
      else if (bus.addr == OFS_HEAD_STATUS)
      begin
        s_d.rdata = s_q.head_st;                             // RULE_03
        s_d.rd_st = 1'b1;
      end
      else if (bus.addr == OFS_HEAD_BCOUNT)
      begin
        s_d.rdata = {4'h0, s_q.head_bc[11:0]};               // RULE_04
        s_d.rd_bc = 1'b1;
      end
      else if (bus.addr == OFS_QUEUE_CTRL)   s_d.rdata = s_q.qctrl;
      else if (bus.addr == OFS_DATA_POINTER) s_d.rdata = s_q.dptr;
      else if (bus.addr == OFS_DUR_THRESH)   s_d.rdata = s_q.dthr;
      else if (bus.addr == OFS_BYTE_THRESH)  s_d.rdata = s_q.bthr;
      else if (bus.addr == OFS_INT_ENABLE)   s_d.rdata = s_q.interrupt_enable;
      else if (bus.addr == OFS_INT_STATUS)   s_d.rdata = s_q.interrupt_status;
      else if (bus.addr == OFS_FRAME_THRESH) s_d.rdata = s_q.fthr;
      else if (bus.addr == OFS_FRAME_COUNT)
      begin
        s_d.rdata = {s_q.fc_snap, 8'h00};
        s_d.head_st = mem[s_q.rbase];                        // RULE_18
        s_d.head_bc = mem[s_q.rbase + AW'(1)];
        s_d.rd_st = 1'b0;
        s_d.rd_bc = 1'b0;
      end
      else if (bus.addr == OFS_DATA_WINDOW &&
               s_q.qctrl[BIT_DMA_START])                     // RULE_05
      begin
        // Data sits after the two header words; first read is dummy
        data_w = mem[s_q.rbase + AW'(2) + AW'(s_q.pos >> 1)];
        s_d.rdata = s_q.dummy ? ALL_ONES : data_w;           // RULE_15
        if (s_q.dummy)
          s_d.dummy = 1'b0;
        else if (s_q.dptr[BIT_AUTO_INC])
          s_d.pos = s_q.pos + 11'd2;                         // RULE_08
      end
    end

    // Both head registers read: show the next frame's header while the
    // data window still reads the current frame
    if (s_d.rd_st && s_d.rd_bc)
    begin
      s_d.rd_st = 1'b0;
      s_d.rd_bc = 1'b0;
      s_d.head_st = mem[s_q.rbase + frame_words(s_q.head_bc)]; // RULE_19
      s_d.head_bc = mem[s_q.rbase + frame_words(s_q.head_bc) + AW'(1)];
    end

    // Dequeue once the frame's data pass is closed
    if (deq)
    begin
      cur_bc = s_q.rbase + AW'(1);
      s_d.rbase = s_q.rbase + frame_words(mem[cur_bc]);      // RULE_06
      s_d.frames = s_d.frames - FW'(1);
      s_d.bytes = s_d.bytes - mem[cur_bc];
      s_d.age_us = '0;
      s_d.pos = '0;
    end

    s_d.irq = s_d.interrupt_status[BIT_RX_INT] & s_q.interrupt_enable[BIT_RX_INT];     // RULE_12
  end

  // ******************************************************************
  // State register
  // ******************************************************************
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // Room for one more word; one word of the store is always kept free
  always_comb
  begin
    in_ready = (s_q.wptr + AW'(1) != s_q.rbase) &&
               (s_q.frames < FW'(MAX_FRAMES)) && s_q.ctrl1[BIT_RX_ENABLE];
  end

  assign bus.rdata    = s_q.rdata;
  assign bus.irq      = s_q.irq;
  assign rx_enable    = s_q.ctrl1[BIT_RX_ENABLE];
  assign rx_flow_ctrl = s_q.ctrl1[BIT_RX_FLOW];
  assign rx_ctrl_two  = s_q.ctrl2;

endmodule : rqh_device

`default_nettype wire

// File: hdl/rqh_host.sv
// Host end: a small sequencer that services a receive interrupt and
// reads one frame into a user-side word stream.
// Assumes the device answers reads one cycle after the strobe.
`default_nettype none

module rqh_host
  import rqh_pkg::*;
(
  input  wire logic  clock,          // System clock
  input  wire logic  reset_n,        // Asynchronous reset, active low
  rqh_if.host        bus,            // Device register port
  input  wire logic  cfg_wr,         // User register write strobe
  input  wire logic [9:0]  cfg_addr, // User register address
  input  wire logic [15:0] cfg_data, // User register data
  output logic       out_valid,      // Frame data word valid
  output logic [15:0] out_word,      // Frame data word
  output logic       busy            // Sequence in progress
);

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_CLR   = 7'b0000010,
    ST_FC    = 7'b0000100,
    ST_HS    = 7'b0001000,
    ST_HB    = 7'b0010000,
    ST_DMA   = 7'b0100000,
    ST_DATA  = 7'b1000000
  } rqh_st_t;

  typedef struct packed {
    rqh_st_t     st;
    logic [9:0]  addr;
    logic [15:0] wdata;
    logic        wr, rd, pend, ov;
    logic [15:0] bc, left, ow;
    logic        first;
  } rqh_host_t;

  rqh_host_t h_q, h_d;

  // ******************************************************************
  // Sequencer
  // ******************************************************************
  always_comb
  begin
    h_d = h_q;
    h_d.wr = 1'b0;
    h_d.rd = 1'b0;
    h_d.ov = 1'b0;
    h_d.pend = 1'b0;
    // A data answer stands the cycle after its window read
    if (h_q.pend)
    begin
      h_d.ov = 1'b1;
      h_d.ow = bus.rdata;
    end
    case (h_q.st)
      ST_IDLE:
        if (cfg_wr)
        begin
          h_d.wr = 1'b1;
          h_d.addr = cfg_addr;
          h_d.wdata = cfg_data;
        end
        else if (bus.irq)
        begin
          h_d.st = ST_CLR;
          h_d.wr = 1'b1;
          h_d.addr = OFS_INT_STATUS;
          h_d.wdata = ALL_ONES;                              // RULE_13
        end
      ST_CLR:
      begin
        h_d.st = ST_FC;
        h_d.rd = 1'b1;
        h_d.addr = OFS_FRAME_COUNT;                          // RULE_17
      end
      ST_FC:
      begin
        h_d.st = ST_HS;
        h_d.rd = 1'b1;
        h_d.addr = OFS_HEAD_STATUS;
      end
      ST_HS:
        // An empty queue ends the service after the count read
        if (bus.rdata[15:8] == 8'h00)
          h_d.st = ST_IDLE;
        else
        begin
          h_d.st = ST_HB;
          h_d.rd = 1'b1;
          h_d.addr = OFS_HEAD_BCOUNT;
        end
      ST_HB:
      begin
        h_d.st = ST_DMA;
        h_d.wr = 1'b1;
        h_d.addr = OFS_QUEUE_CTRL;
        h_d.wdata = 16'h0018;                                // RULE_05
      end
      ST_DMA:
      begin
        h_d.bc = bus.rdata;
        h_d.left = ((bus.rdata + 16'h0003) & 16'hfffc) >> 1; // RULE_16
        h_d.first = 1'b1;
        h_d.st = ST_DATA;
        h_d.rd = 1'b1;
        h_d.addr = OFS_DATA_WINDOW;
      end
      ST_DATA:
      begin
        h_d.pend = h_q.rd && !h_q.first;                     // RULE_15
        h_d.first = 1'b0;
        if (h_q.left == 16'h0000)
        begin
          h_d.st = ST_IDLE;
          h_d.wr = 1'b1;
          h_d.addr = OFS_QUEUE_CTRL;
          h_d.wdata = 16'h0010;
        end
        else
        begin
          h_d.left = h_q.left - 16'h0001;
          h_d.rd = 1'b1;
        end
      end
      default:
        h_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      h_q <= '{st: ST_IDLE, default: '0};
    else
      h_q <= h_d;
  end

  assign bus.addr  = h_q.addr;
  assign bus.wdata = h_q.wdata;
  assign bus.wr    = h_q.wr;
  assign bus.rd    = h_q.rd;
  assign out_valid = h_q.ov;
  assign out_word  = h_q.ow;
  assign busy      = (h_q.st != ST_IDLE);

endmodule : rqh_host

`default_nettype wire

// File: hdl/rqh_if.sv
// Interface joining the host end to the receive queue device end.
// Assumes both ends share one clock; read data stands one cycle later.
`default_nettype none

interface rqh_if;
  logic [9:0]  addr;     // Register byte address
  logic [15:0] wdata;    // Write data
  logic        wr;       // Write strobe
  logic        rd;       // Read strobe
  logic [15:0] rdata;    // Read data, cycle after rd
  logic        irq;      // Receive interrupt, active high

  modport device (input addr, wdata, wr, rd, output rdata, irq);
  modport host   (output addr, wdata, wr, rd, input rdata, irq);
endinterface : rqh_if

`default_nettype wire

// File: hdl/rqh_pkg.sv
// Package for the receive queue host-read block: register map, field
// positions, reset values and timing counts shared by both ends.
// Assumes a 10 MHz system clock and a 16-bit host register word.
`default_nettype none

package rqh_pkg;

  // ******************************************************************
  // Register offsets (byte addresses on the host bus)
  // ******************************************************************
  localparam logic [9:0] OFS_RX_CTRL_ONE   = 10'h174;
  localparam logic [9:0] OFS_RX_CTRL_TWO   = 10'h176;
  localparam logic [9:0] OFS_HEAD_STATUS   = 10'h17c;
  localparam logic [9:0] OFS_HEAD_BCOUNT   = 10'h17e;
  localparam logic [9:0] OFS_QUEUE_CTRL    = 10'h182;
  localparam logic [9:0] OFS_DATA_POINTER  = 10'h186;
  localparam logic [9:0] OFS_DUR_THRESH    = 10'h18c;
  localparam logic [9:0] OFS_BYTE_THRESH   = 10'h18e;
  localparam logic [9:0] OFS_INT_ENABLE    = 10'h190;
  localparam logic [9:0] OFS_INT_STATUS    = 10'h192;
  localparam logic [9:0] OFS_FRAME_THRESH  = 10'h19c;
  localparam logic [9:0] OFS_FRAME_COUNT   = 10'h1b8;
  localparam logic [9:0] OFS_DATA_WINDOW   = 10'h1c0;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int BIT_RX_FLOW      = 10;
  localparam int BIT_RX_ENABLE    = 0;
  localparam int BIT_DMA_START    = 3;
  localparam int BIT_AUTO_DEQ     = 4;
  localparam int BIT_FCNT_EN      = 5;
  localparam int BIT_BCNT_EN      = 6;
  localparam int BIT_DUR_EN       = 7;
  localparam int BIT_IP_OFFSET    = 9;
  localparam int BIT_FCNT_STAT    = 10;
  localparam int BIT_BCNT_STAT    = 11;
  localparam int BIT_DUR_STAT     = 12;
  localparam int BIT_AUTO_INC     = 14;
  localparam int BIT_RX_INT       = 13;

  // Writable bits of queue control (status bits 12:10 are read-only)
  localparam logic [15:0] QCTRL_WR_MASK = 16'h02f8;
  localparam logic [15:0] ALL_ONES      = 16'hffff;
  localparam logic [15:0] RESET_ZERO    = 16'h0000;

  // ******************************************************************
  // Frame layout and timing
  // ******************************************************************
  localparam int MAX_FRAME_BYTES = 2000;
  localparam int CLOCK_HZ        = 10_000_000;
  localparam int TICK_US         = 1;
  localparam int TICK_CYCLES     = CLOCK_HZ / 1_000_000 * TICK_US;

endpackage : rqh_pkg

`default_nettype wire

// File: sim/rqh_checker.sv
// Checker for the host register port joining the two ends.
// Assumes one clock and the interface signals as plain inputs.
`default_nettype none

module rqh_checker
  import rqh_pkg::*;
(
  input wire logic        clock,   // System clock
  input wire logic        reset_n, // Reset, active low
  input wire logic [9:0]  addr,    // Byte address
  input wire logic [15:0] wdata,   // Write data
  input wire logic        wr,      // Write strobe
  input wire logic        rd,      // Read strobe
  input wire logic [15:0] rdata,   // Read data
  input wire logic        irq      // Receive interrupt
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  logic [15:0] ien_q;   // Shadow of interrupt enable
  logic [15:0] qctl_q;  // Shadow of queue control
  logic        first_q; // Next window read is the dummy
  logic        clr_q;   // Status cleared since last count read
  logic [7:0]  win_q;   // Window reads in this DMA pass

  // ******************************************************************
  // Shadows, kept from the strobes alone
  // ******************************************************************
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ien_q   <= 16'h0000;
      qctl_q  <= 16'h0000;
      first_q <= 1'b0;
      clr_q   <= 1'b0;
      win_q   <= 8'h00;
    end
    else
    begin
      if (wr && addr == OFS_INT_ENABLE)
        ien_q <= wdata;
      if (wr && addr == OFS_QUEUE_CTRL)
        qctl_q <= wdata;
      if (wr && addr == OFS_QUEUE_CTRL && wdata[BIT_DMA_START])
      begin
        first_q <= 1'b1;
        win_q   <= 8'h00;
      end
      else if (rd && addr == OFS_DATA_WINDOW)
      begin
        first_q <= 1'b0;
        win_q   <= win_q + 8'h01;
      end
      if (wr && addr == OFS_INT_STATUS && wdata[BIT_RX_INT])
        clr_q <= 1'b1;
      else if (rd && addr == OFS_FRAME_COUNT)
        clr_q <= 1'b0;
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  sequence s_win_read;
    rd && addr == OFS_DATA_WINDOW;
  endsequence

  sequence s_dma_close;
    wr && addr == OFS_QUEUE_CTRL && !wdata[BIT_DMA_START]
      && qctl_q[BIT_DMA_START];
  endsequence

  a_strobe_single: assert property (!(wr && rd))
    else $error("read and write strobes together");
  a_window_open: assert property (s_win_read |-> qctl_q[BIT_DMA_START])
    else $error("window read without DMA start");
  a_dummy_first: assert property (rd && addr == OFS_DATA_WINDOW && first_q |=> rdata == ALL_ONES)
    else $error("first window read is not the dummy");
  // An odd total means dummy plus whole double words
  a_dword_end: assert property (s_dma_close |-> win_q[0])
    else $error("DMA pass not ending on a double word");
  a_clear_first: assert property (rd && addr == OFS_FRAME_COUNT |-> clr_q)
    else $error("frame count read without status clear");
  a_irq_gate: assert property (!ien_q[BIT_RX_INT] && !$past(ien_q[BIT_RX_INT]) |-> !irq)
    else $error("interrupt while disabled");
  a_irq_drop: assert property (wr && addr == OFS_INT_ENABLE && !wdata[BIT_RX_INT] |-> ##[1:2] !irq)
    else $error("interrupt stays after disable");
  a_irq_source: assert property ($rose(irq) |-> qctl_q[BIT_DUR_EN:BIT_FCNT_EN] != 3'h0)
    else $error("interrupt with no threshold enabled");
endmodule : rqh_checker

`default_nettype wire

// File: sim/tb.sv
// Bench for the receive queue pair: frames go into the device, the
// host services each interrupt and streams the frame data out.
// Assumes the package, interface, both ends and the checker.
`default_nettype none

module tb;
  import rqh_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock, reset_n, in_valid, in_last, in_ready, cfg_wr;
  logic        out_valid, busy, rx_enable, rx_flow_ctrl, rd_p;
  logic [15:0] in_word, cfg_data, out_word, rx_ctrl_two, c2;
  logic [9:0]  cfg_addr, addr_p;
  logic [15:0] exp_q[$], stat_q[$], bcnt_q[$];
  logic [7:0]  fcnt_q[$];
  int          failures, comparisons, seed;

  rqh_if bus_if ();

  rqh_device rqh_device_inst (.clock(clock), .reset_n(reset_n),
    .bus(bus_if), .in_valid(in_valid), .in_word(in_word),
    .in_last(in_last), .in_ready(in_ready), .rx_enable(rx_enable),
    .rx_flow_ctrl(rx_flow_ctrl), .rx_ctrl_two(rx_ctrl_two));
  rqh_host rqh_host_inst (.clock(clock), .reset_n(reset_n),
    .bus(bus_if), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_data(cfg_data), .out_valid(out_valid), .out_word(out_word),
    .busy(busy));
  rqh_checker rqh_checker_inst (.clock(clock), .reset_n(reset_n),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr),
    .rd(bus_if.rd), .rdata(bus_if.rdata), .irq(bus_if.irq));

  // 10 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Register write handed to the host, which passes it on when idle
  task automatic cfg(input logic [9:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000)
    begin
      @(posedge clock);
      n++;
    end
    cfg_wr   <= 1'b1;
    cfg_addr <= a;
    cfg_data <= d;
    @(posedge clock);
    cfg_wr <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  // Frame in: status, byte count, data; notes what must come back
  task automatic push(input int nbytes);
    logic [15:0] w[$];
    bit          ok;
    w.push_back(16'($random(seed)));
    w.push_back(16'(nbytes));
    stat_q.push_back(w[0]);
    bcnt_q.push_back(w[1]);
    for (int i = 0; i < nbytes / 2; i++)
    begin
      w.push_back(16'($random(seed)));
      exp_q.push_back(w[i + 2]);
    end
    foreach (w[i])
    begin
      in_valid <= 1'b1;
      in_word  <= w[i];
      in_last  <= (i == w.size() - 1);
      do
      begin
        @(negedge clock);
        ok = in_ready;
        @(posedge clock);
      end while (!ok);
    end
    in_valid <= 1'b0;
    in_last  <= 1'b0;
  endtask

  // Wait, bounded, until every noted word has come out
  task automatic drain(input string name);
    int n;
    n = 0;
    repeat (4) @(posedge clock);
    while ((exp_q.size() != 0 || busy !== 1'b0) && n < 3000)
    begin
      @(posedge clock);
      n++;
    end
    if (n == 3000)
      failures++;
    $display("test %s done", name);
  endtask

  // Read answers stand the cycle after the strobe; words as they come
  always @(posedge clock)
  begin
    if (rd_p && addr_p == OFS_FRAME_COUNT)
      check("frame count", {8'h00, bus_if.rdata[15:8]}, {8'h00, fcnt_q.pop_front()});
    if (rd_p && addr_p == OFS_HEAD_STATUS)
      check("head status", bus_if.rdata, stat_q.pop_front());
    if (rd_p && addr_p == OFS_HEAD_BCOUNT)
      check("head count", {4'h0, bus_if.rdata[11:0]}, bcnt_q.pop_front());
    if (out_valid)
      check("out word", out_word, exp_q.pop_front());
    rd_p   <= bus_if.rd;
    addr_p <= bus_if.addr;
  end

  // Watchdog, well past the few hundred cycles the tests need
  initial
  begin
    #(100 * 20000);
    failures++;
    results();
  end

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial
  begin
    seed = 89;
    failures = 0;
    comparisons = 0;
    reset_n = 1'b0;
    {in_valid, in_last, cfg_wr, rd_p} = 4'h0;
    {in_word, cfg_data, cfg_addr, addr_p} = '0;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    // Control one with enable, then flow control, then both
    for (int i = 1; i < 4; i++)
    begin
      cfg(OFS_RX_CTRL_ONE, {5'h00, i[1], 9'h000, i[0]});
      check("rx enable", {15'h0000, rx_enable}, {15'h0000, i[0]});
      check("flow control", {15'h0000, rx_flow_ctrl}, {15'h0000, i[1]});
    end
    c2 = 16'($random(seed));
    cfg(OFS_RX_CTRL_TWO, c2);
    check("control two", rx_ctrl_two, c2);
    $display("test controls done");
    // One frame sits at the frame threshold, a second exceeds it
    cfg(OFS_DATA_POINTER, 16'h4000);
    cfg(OFS_INT_ENABLE, 16'h2000);
    cfg(OFS_FRAME_THRESH, 16'h0001);
    cfg(OFS_QUEUE_CTRL, 16'h0020);
    push(8);
    repeat (20) @(posedge clock);
    check("irq at threshold", {15'h0000, bus_if.irq}, 16'h0000);
    fcnt_q.push_back(8'h02);
    fcnt_q.push_back(8'h01);
    push(12);
    drain("frame threshold");
    // Duration over 3 us; quiet well before that
    cfg(OFS_DUR_THRESH, 16'h0003);
    cfg(OFS_QUEUE_CTRL, 16'h0080);
    fcnt_q.push_back(8'h01);
    fcnt_q.push_back(8'h00);
    push(4);
    repeat (10) @(posedge clock);
    check("irq early", {15'h0000, bus_if.irq}, 16'h0000);
    drain("duration");
    // Byte threshold met while disabled, then enabled
    cfg(OFS_INT_ENABLE, 16'h0000);
    cfg(OFS_BYTE_THRESH, 16'h0000);
    cfg(OFS_QUEUE_CTRL, 16'h0040);
    push(16);
    repeat (20) @(posedge clock);
    check("irq masked", {15'h0000, bus_if.irq}, 16'h0000);
    fcnt_q.push_back(8'h01);
    fcnt_q.push_back(8'h00);
    cfg(OFS_INT_ENABLE, 16'h2000);
    drain("enable gate");
    results();
  end
endmodule : tb

`default_nettype wire
